// >>> core/qenc_pkg.sv
/*
  Shared constants for the four-channel quadrature encoder block:
  register indices, field positions, reset values and mode encodings.
  Assumes a 32-bit AHB-Lite register bus, one word per register.
*/
package qenc_pkg;
  // per-channel window: byte address = CH_STRIDE * ch + 4 * index
  localparam int CH_STRIDE = 32;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_POS = 3'h1;
  localparam logic [2:0] REG_IDX = 3'h2;
  localparam logic [2:0] REG_CAP = 3'h3;
  localparam logic [2:0] REG_BPPOS = 3'h4;
  localparam logic [2:0] REG_BPPER = 3'h5;
  localparam logic [2:0] REG_STAT = 3'h6;
  localparam logic [2:0] REG_CMD = 3'h7;
  // global window at 0x80
  localparam logic [2:0] GLB_CTRL = 3'h0;
  localparam logic [2:0] GLB_STAT = 3'h1;
  // channel control fields
  localparam int CTL_POLA = 0;
  localparam int CTL_POLB = 1;
  localparam int CTL_POLZ = 2;
  localparam int CTL_PATA = 3;
  localparam int CTL_PATB = 4;
  localparam int CTL_TRIGEN = 5;
  localparam int CTL_TRIGINV = 6;
  localparam int CTL_BPEN = 7;
  localparam int CTL_BPMODE = 8;
  localparam int CTL_BPACT = 10;
  localparam int CTL_FILT = 16;
  localparam int FILT_W = 4;
  // command bits, write-only
  localparam int CMD_ARMIDX = 0;
  localparam int CMD_ARMCAP = 1;
  localparam int CMD_ARMBP = 2;
  localparam int CMD_FORCE = 3;
  localparam int CMD_FORCEVAL = 4;
  localparam int CMD_CLRERR = 5;
  localparam int CMD_CLRTRIG = 6;
  // status bits
  localparam int ST_IDXFOUND = 0;
  localparam int ST_SEARCH = 1;
  localparam int ST_CAPDONE = 2;
  localparam int ST_BPARMED = 3;
  localparam int ST_BPDONE = 4;
  localparam int ST_DECERR = 5;
  localparam int ST_BPOUT = 6;
  localparam int ST_TRIGLAT = 7;
  localparam int ST_INPUTS = 8;
  // global control / status
  localparam int GCTL_HALTEN = 0;
  localparam int GCTL_FILT = 4;
  localparam int GST_HALTED = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] GCTRL_RST = 8'h00;
  typedef enum logic [1:0] {
    BP_ABS = 2'b00,
    BP_MOD = 2'b01,
    BP_REL = 2'b10
  } bp_mode_type;
  typedef enum logic [1:0] {
    ACT_RISE = 2'b00,
    ACT_FALL = 2'b01,
    ACT_TOGGLE = 2'b10
  } bp_act_type;
endpackage

// >>> core/qenc_filter.sv
/*
  Two-flop synchroniser followed by a stability filter for one pin.
  Assumes rawIn is asynchronous to clk; limit comes from a clk register.
*/
module qenc_filter
  import qenc_pkg::*;
#(
  parameter int W = FILT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rawIn,
  input wire logic [W-1:0] limit,
  output logic level
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    logic [W-1:0] cnt;
  } filt_state_type;
  filt_state_type st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = rawIn;
    st_next.sync2 = st_reg.sync1;
    if (st_reg.sync2 == st_reg.level) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= limit) begin
      st_next.level = st_reg.sync2; // (R23)
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.level;

  filt_stable_a: assert property (@(posedge clk) disable iff (rst) // (R23)
    $changed(st_reg.level) |-> $past(st_reg.cnt) >= $past(limit))
    else $error("filter passed an unstable level");
endmodule

// >>> core/quadrature_encoder_capture_breakpoint.sv
/*
  Four-channel quadrature decoder with index search, trigger capture,
  position-match outputs and a global halt, behind an AHB-Lite slave.
  Assumes all encoder, trigger and halt pins are asynchronous to clk.
*/
// Overview of operation
// (R1) four independent channels, each with phase A, phase B and marker inputs
// (R2) each channel keeps a 32-bit signed up/down position count
// (R3) the leading phase sets direction: one order counts up, the other down
// (R4) every edge of either phase counts, four counts per line cycle
// (R5) the encoder must drive both phases about a quarter cycle apart
// (R6) a valid marker during a search latches the count as reference
// (R7) by default a marker is valid while high with both phases low
// (R8) software selects the phase pattern that qualifies a marker
// (R9) phase A, phase B and marker polarity each selectable by software
// (R10) all encoder inputs pass a programmable digital filter first
// (R11) counting works without the marker; only the search needs it
// (R12) an enabled trigger edge latches the channel count into capture
// (R13) trigger sense selectable, giving rising or falling edge detection
// (R14) the trigger event is latched and readable as a general input
// (R15) enabled halt asserts inhibits, zeroes analog and stops step pulses
// (R16) halt acts only on a low-to-high transition of its input
// (R17) the match output changes when the count equals the breakpoint
// (R18) breakpoints are absolute, modulo or relative to current position
// (R19) output presettable; a match drives it high, low or toggles it
// (R20) software may set and clear each match output directly
// (R21) both phases changing in one sample is an error, not a count
// (R22) capture or match sets a flag and holds until software re-arms
// (R23) the filter passes a level only after it stays stable long enough
module quadrature_encoder_capture_breakpoint
  import qenc_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NUM_CH-1:0] encA,
  input wire logic [NUM_CH-1:0] encB,
  input wire logic [NUM_CH-1:0] encZ,
  input wire logic [NUM_CH-1:0] trigIn,
  input wire logic haltIn,
  output logic [NUM_CH-1:0] bpOut,
  output logic driveInhibit,
  output logic dacZero,
  output logic stepStop
);
  generate
    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad
      $error("NUM_CH must be 1 to 4");
    end
  endgenerate

  typedef struct packed {
    logic [NUM_CH-1:0][31:0] ctrl;
    logic [NUM_CH-1:0][31:0] count;
    logic [NUM_CH-1:0][31:0] idxPos;
    logic [NUM_CH-1:0][31:0] capPos;
    logic [NUM_CH-1:0][31:0] bpPos;
    logic [NUM_CH-1:0][31:0] bpPer;
    logic [NUM_CH-1:0][31:0] target;
    logic [NUM_CH-1:0] prevA;
    logic [NUM_CH-1:0] prevB;
    logic [NUM_CH-1:0] prevIdx;
    logic [NUM_CH-1:0] prevTrig;
    logic [NUM_CH-1:0] lastUp;
    logic [NUM_CH-1:0] search;
    logic [NUM_CH-1:0] idxFound;
    logic [NUM_CH-1:0] capDone;
    logic [NUM_CH-1:0] bpArmed;
    logic [NUM_CH-1:0] bpDone;
    logic [NUM_CH-1:0] decErr;
    logic [NUM_CH-1:0] trigLat;
    logic [NUM_CH-1:0] bpOut;
    logic [7:0] glbCtrl;
    logic prevHalt;
    logic halted;
    logic dValid;
    logic dWrite;
    logic [7:0] dAddr;
    logic [31:0] rdata;
    logic readyOut;
  } state_type;
  state_type st_reg, st_next;

  logic [NUM_CH-1:0][3:0] filt;
  logic [NUM_CH-1:0] aF, bF, zF, tF;
  logic [NUM_CH-1:0] stepUp, stepDn, bothCh, idxRise, trigEdge, bpHit;
  logic [NUM_CH-1:0] posWr, cmdWr;
  logic haltF, haltRise, wrEn;
  logic [1:0] rch;
  logic [31:0] rd;

  function automatic logic regHit(input logic [7:0] a, input logic [1:0] ch,
                                  input logic [2:0] idx);
    return !a[7] && a[6:5] == ch && a[4:2] == idx;
  endfunction

  genvar gc, gs;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch // (R1)
      for (gs = 0; gs < 4; gs++) begin : g_sig
        qenc_filter #(.W(FILT_W)) u_filt ( // (R10)
          .clk(clk),
          .rst(rst),
          .rawIn(gs == 0 ? encA[gc] : gs == 1 ? encB[gc] : gs == 2 ? encZ[gc] : trigIn[gc]),
          .limit(st_reg.ctrl[gc][CTL_FILT +: FILT_W]),
          .level(filt[gc][gs])
        );
      end
    end
  endgenerate

  qenc_filter #(.W(FILT_W)) u_halt_filt (
    .clk(clk),
    .rst(rst),
    .rawIn(haltIn),
    .limit(st_reg.glbCtrl[GCTL_FILT +: FILT_W]),
    .level(haltF)
  );

  always_comb begin
    st_next = st_reg;
    aF = '0;
    bF = '0;
    zF = '0;
    tF = '0;
    stepUp = '0;
    stepDn = '0;
    bothCh = '0;
    idxRise = '0;
    trigEdge = '0;
    bpHit = '0;
    posWr = '0;
    cmdWr = '0;
    rch = haddr[6:5];
    rd = '0;
    wrEn = st_reg.dValid && st_reg.dWrite;
    for (int c = 0; c < NUM_CH; c++) begin
      aF[c] = filt[c][0] ^ st_reg.ctrl[c][CTL_POLA]; // (R9)
      bF[c] = filt[c][1] ^ st_reg.ctrl[c][CTL_POLB]; // (R9)
      zF[c] = filt[c][2] ^ st_reg.ctrl[c][CTL_POLZ]; // (R9)
      tF[c] = filt[c][3] ^ st_reg.ctrl[c][CTL_TRIGINV]; // (R13)
      // a missing phase makes the edges of the other step the count one way, then back, never a net count (R5)
      bothCh[c] = (aF[c] ^ st_reg.prevA[c]) && (bF[c] ^ st_reg.prevB[c]); // (R21)
      stepUp[c] = ((aF[c] ^ st_reg.prevA[c]) ^ (bF[c] ^ st_reg.prevB[c]))
                  && !(st_reg.prevA[c] ^ bF[c]); // (R3)
      stepDn[c] = ((aF[c] ^ st_reg.prevA[c]) ^ (bF[c] ^ st_reg.prevB[c]))
                  && (st_reg.prevA[c] ^ bF[c]); // (R3)
      st_next.prevA[c] = aF[c];
      st_next.prevB[c] = bF[c];
      // counting ignores the marker entirely (R11)
      if (stepUp[c]) begin
        st_next.count[c] = st_reg.count[c] + 32'h1; // (R2) (R4)
        st_next.lastUp[c] = 1'b1;
      end else if (stepDn[c]) begin
        st_next.count[c] = st_reg.count[c] - 32'h1; // (R2) (R4)
        st_next.lastUp[c] = 1'b0;
      end
      idxRise[c] = zF[c] && aF[c] == st_reg.ctrl[c][CTL_PATA]
                   && bF[c] == st_reg.ctrl[c][CTL_PATB] && !st_reg.prevIdx[c]; // (R7) (R8)
      st_next.prevIdx[c] = zF[c] && aF[c] == st_reg.ctrl[c][CTL_PATA]
                           && bF[c] == st_reg.ctrl[c][CTL_PATB];
      trigEdge[c] = tF[c] && !st_reg.prevTrig[c] && st_reg.ctrl[c][CTL_TRIGEN]; // (R12) (R13)
      st_next.prevTrig[c] = tF[c];
      bpHit[c] = st_reg.bpArmed[c] && st_reg.ctrl[c][CTL_BPEN]
                 && st_reg.count[c] == st_reg.target[c]; // (R17)
      // bus writes: a position write wins over a step in the same cycle
      posWr[c] = wrEn && regHit(st_reg.dAddr, 2'(c), REG_POS);
      cmdWr[c] = wrEn && regHit(st_reg.dAddr, 2'(c), REG_CMD);
      if (wrEn && regHit(st_reg.dAddr, 2'(c), REG_CTRL)) begin
        st_next.ctrl[c] = hwdata;
      end
      if (posWr[c]) begin
        st_next.count[c] = hwdata;
      end
      if (wrEn && regHit(st_reg.dAddr, 2'(c), REG_BPPOS)) begin
        st_next.bpPos[c] = hwdata;
      end
      if (wrEn && regHit(st_reg.dAddr, 2'(c), REG_BPPER)) begin
        st_next.bpPer[c] = hwdata;
      end
      if (cmdWr[c]) begin
        if (hwdata[CMD_ARMIDX]) begin
          st_next.search[c] = 1'b1;
          st_next.idxFound[c] = 1'b0;
        end
        if (hwdata[CMD_ARMCAP]) begin
          st_next.capDone[c] = 1'b0; // (R22)
        end
        if (hwdata[CMD_ARMBP]) begin
          st_next.bpArmed[c] = 1'b1;
          st_next.bpDone[c] = 1'b0;
          st_next.target[c] = bp_mode_type'(st_reg.ctrl[c][CTL_BPMODE +: 2]) == BP_REL
                              ? st_reg.count[c] + st_reg.bpPos[c] : st_reg.bpPos[c]; // (R18)
        end
        if (hwdata[CMD_FORCE]) begin
          st_next.bpOut[c] = hwdata[CMD_FORCEVAL]; // (R19) (R20)
        end
        if (hwdata[CMD_CLRERR]) begin
          st_next.decErr[c] = 1'b0;
        end
        if (hwdata[CMD_CLRTRIG]) begin
          st_next.trigLat[c] = 1'b0;
        end
      end
      // hardware events last, so a set beats a clear in the same cycle
      if (bothCh[c]) begin
        st_next.decErr[c] = 1'b1; // (R21)
      end
      if (st_reg.search[c] && idxRise[c]) begin
        st_next.idxPos[c] = st_reg.count[c]; // (R6)
        st_next.idxFound[c] = 1'b1;
        st_next.search[c] = 1'b0;
      end
      if (trigEdge[c]) begin
        st_next.trigLat[c] = 1'b1; // (R14)
        if (!st_reg.capDone[c] || (cmdWr[c] && hwdata[CMD_ARMCAP])) begin
          st_next.capPos[c] = st_reg.count[c]; // (R12)
          st_next.capDone[c] = 1'b1; // (R22)
        end
      end
      if (bpHit[c]) begin
        st_next.bpDone[c] = 1'b1; // (R22)
        unique case (st_reg.ctrl[c][CTL_BPACT +: 2])
          ACT_RISE: st_next.bpOut[c] = 1'b1; // (R19)
          ACT_FALL: st_next.bpOut[c] = 1'b0; // (R19)
          ACT_TOGGLE: st_next.bpOut[c] = !st_reg.bpOut[c]; // (R19)
          default: st_next.bpOut[c] = st_reg.bpOut[c];
        endcase
        // modulo steps the target in the travel direction; a reversal
        // right after a hit skips the point just behind
        if (bp_mode_type'(st_reg.ctrl[c][CTL_BPMODE +: 2]) == BP_MOD) begin
          st_next.target[c] = st_reg.lastUp[c] ? st_reg.target[c] + st_reg.bpPer[c]
                              : st_reg.target[c] - st_reg.bpPer[c]; // (R18)
        end else begin
          st_next.bpArmed[c] = 1'b0;
        end
      end
    end
    haltRise = haltF && !st_reg.prevHalt && st_reg.glbCtrl[GCTL_HALTEN]; // (R16)
    st_next.prevHalt = haltF;
    if (wrEn && st_reg.dAddr[7] && st_reg.dAddr[4:2] == GLB_CTRL) begin
      st_next.glbCtrl = hwdata[7:0];
    end
    if (wrEn && st_reg.dAddr[7] && st_reg.dAddr[4:2] == GLB_STAT && hwdata[GST_HALTED]) begin
      st_next.halted = 1'b0;
    end
    if (haltRise) begin
      st_next.halted = 1'b1; // (R15)
    end
    // read mux, sampled in the address phase
    if (haddr[7]) begin
      if (haddr[4:2] == GLB_CTRL) begin
        rd[7:0] = st_reg.glbCtrl;
      end else if (haddr[4:2] == GLB_STAT) begin
        rd[GST_HALTED] = st_reg.halted;
      end
    end else if (32'(rch) < NUM_CH) begin
      unique case (haddr[4:2])
        REG_CTRL: rd = st_reg.ctrl[rch];
        REG_POS: rd = st_reg.count[rch];
        REG_IDX: rd = st_reg.idxPos[rch];
        REG_CAP: rd = st_reg.capPos[rch];
        REG_BPPOS: rd = st_reg.bpPos[rch];
        REG_BPPER: rd = st_reg.bpPer[rch];
        REG_STAT: begin
          rd[ST_IDXFOUND] = st_reg.idxFound[rch];
          rd[ST_SEARCH] = st_reg.search[rch];
          rd[ST_CAPDONE] = st_reg.capDone[rch];
          rd[ST_BPARMED] = st_reg.bpArmed[rch];
          rd[ST_BPDONE] = st_reg.bpDone[rch];
          rd[ST_DECERR] = st_reg.decErr[rch];
          rd[ST_BPOUT] = st_reg.bpOut[rch];
          rd[ST_TRIGLAT] = st_reg.trigLat[rch];
          rd[ST_INPUTS +: 4] = {tF[rch], zF[rch], bF[rch], aF[rch]};
        end
        REG_CMD: rd = '0;
      endcase
    end
    st_next.dValid = hsel && htrans[1] && hready;
    st_next.dWrite = hwrite;
    st_next.dAddr = haddr[7:0];
    st_next.rdata = (hsel && htrans[1] && hready && !hwrite) ? rd : '0;
    st_next.readyOut = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.ctrl <= {NUM_CH{CTRL_RST}};
      st_reg.glbCtrl <= GCTRL_RST;
      st_reg.capDone <= '1;
      st_reg.readyOut <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata = st_reg.rdata;
  assign hreadyout = st_reg.readyOut;
  assign hresp = 1'b0;
  assign bpOut = st_reg.bpOut;
  assign driveInhibit = st_reg.halted; // (R15)
  assign dacZero = st_reg.halted; // (R15)
  assign stepStop = st_reg.halted; // (R15)

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  quad_up_a: assert property ( // (R3) (R4)
    stepUp[0] && !posWr[0] |=> st_reg.count[0] == $past(st_reg.count[0]) + 32'h1)
    else $error("count did not step up");
  quad_dn_a: assert property ( // (R2)
    stepDn[0] && !posWr[0] |=> st_reg.count[0] == $past(st_reg.count[0]) - 32'h1)
    else $error("count did not step down");
  dec_err_a: assert property ( // (R21)
    bothCh[0] && !posWr[0] |=> st_reg.decErr[0] && $stable(st_reg.count[0]))
    else $error("double change counted or not flagged");
  idx_latch_a: assert property ( // (R6)
    st_reg.search[0] && idxRise[0] |=> st_reg.idxFound[0] && !st_reg.search[0]
      && st_reg.idxPos[0] == $past(st_reg.count[0]))
    else $error("marker did not latch position");
  idx_pat_a: assert property ( // (R7) (R8)
    $rose(st_reg.idxFound[0]) |-> $past(zF[0])
      && $past(aF[0]) == $past(st_reg.ctrl[0][CTL_PATA])
      && $past(bF[0]) == $past(st_reg.ctrl[0][CTL_PATB]))
    else $error("reference found without qualifying pattern");
  cap_latch_a: assert property ( // (R12) (R13)
    trigEdge[0] && !st_reg.capDone[0]
      |=> st_reg.capDone[0] && st_reg.trigLat[0] && st_reg.capPos[0] == $past(st_reg.count[0]))
    else $error("trigger did not capture");
  cap_hold_a: assert property ( // (R22)
    st_reg.capDone[0] && !(cmdWr[0] && hwdata[CMD_ARMCAP]) |=> $stable(st_reg.capPos[0]))
    else $error("capture changed before re-arm");
  halt_set_a: assert property ( // (R15)
    haltRise |=> driveInhibit && dacZero && stepStop)
    else $error("halt did not stop motion");
  halt_edge_a: assert property ( // (R16)
    $rose(st_reg.halted) |-> $past(haltRise))
    else $error("halt set without rising edge");
  bp_tog_a: assert property ( // (R17) (R19)
    bpHit[0] && st_reg.ctrl[0][CTL_BPACT +: 2] == ACT_TOGGLE |=> bpOut[0] != $past(bpOut[0]))
    else $error("match did not toggle output");
  bp_force_a: assert property ( // (R20)
    cmdWr[0] && hwdata[CMD_FORCE] && !bpHit[0] |=> bpOut[0] == $past(hwdata[CMD_FORCEVAL]))
    else $error("direct output write lost");
  bp_rel_a: assert property ( // (R18)
    cmdWr[0] && hwdata[CMD_ARMBP] && st_reg.ctrl[0][CTL_BPMODE +: 2] == BP_REL
      |=> st_reg.target[0] == $past(st_reg.count[0]) + $past(st_reg.bpPos[0]))
    else $error("relative target wrong");

  idx_found_c: cover property (st_reg.search[0] && idxRise[0]);
  cap_seen_c: cover property (trigEdge[0] && !st_reg.capDone[0]);
  bp_hit_c: cover property (bpHit[0]);
  halt_seen_c: cover property (haltRise);
endmodule

// >>> dv/encoder_model.sv
/*
  Behavioural far side: four incremental encoders plus trigger sensors.
  Assumes clk is the block clock; every pin changes by NBA just after a
  rising edge and each level but a glitch pulse is held for HOLD cycles.
*/
module encoder_model (
  input wire logic clk,
  output logic [3:0] encA,
  output logic [3:0] encB,
  output logic [3:0] encZ,
  output logic [3:0] trigIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // long enough for the largest filter count used by the bench
  localparam int HOLD = 16;
  logic [1:0] phase [4];

  initial begin
    encA = '0;
    encB = '0;
    encZ = '0;
    trigIn = '0;
    phase = '{default: 2'h0};
  end

  task automatic settle();
    repeat (HOLD) @(posedge clk);
  endtask

  task automatic drivePhase(input int ch);
    encA[ch] <= (phase[ch] == 2'h1) || (phase[ch] == 2'h2);
    encB[ch] <= phase[ch][1];
  endtask

  // gray sequence 00,10,11,01: only one phase moves per step
  task automatic move(input int ch, input int n);
    int k = (n < 0) ? -n : n;
    for (int i = 0; i < k; i++) begin
      @(posedge clk);
      phase[ch] = (n < 0) ? phase[ch] - 2'h1 : phase[ch] + 2'h1;
      drivePhase(ch);
      settle();
    end
  endtask

  // deliberately breaks the quarter-cycle spacing: both phases flip
  task automatic jump(input int ch);
    @(posedge clk);
    phase[ch] = phase[ch] + 2'h2;
    drivePhase(ch);
    settle();
  endtask

  task automatic glitch(input int ch, input int len);
    @(posedge clk);
    encA[ch] <= ~encA[ch];
    repeat (len) @(posedge clk);
    encA[ch] <= ~encA[ch];
    settle();
  endtask

  task automatic marker(input int ch);
    @(posedge clk);
    encZ[ch] <= 1'b1;
    settle();
    encZ[ch] <= 1'b0;
    settle();
  endtask

  task automatic trig(input int ch, input logic v);
    @(posedge clk);
    trigIn[ch] <= v;
    settle();
  endtask
endmodule

// >>> dv/quadrature_encoder_capture_breakpoint_tb.sv
/*
  Self-checking bench: AHB-Lite master tasks plus encoder model stimulus.
  Assumes the zero-wait-state slave and register map of the block.
*/
module quadrature_encoder_capture_breakpoint_tb
  import qenc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] encA, encB, encZ, trigIn, bpOut;
  logic haltIn = 1'b1;
  logic driveInhibit, dacZero, stepStop;
  int failures = 0;
  int checks = 0;

  always #2.5 clk = ~clk;

  quadrature_encoder_capture_breakpoint u_dut (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .encA(encA), .encB(encB), .encZ(encZ), .trigIn(trigIn), .haltIn(haltIn),
    .bpOut(bpOut), .driveInhibit(driveInhibit), .dacZero(dacZero), .stepStop(stepStop));

  encoder_model u_enc (.clk(clk), .encA(encA), .encB(encB), .encZ(encZ), .trigIn(trigIn));

  task automatic close_out();
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] chAddr(input int ch, input logic [2:0] idx);
    return 32'(CH_STRIDE * ch) + {27'h0, idx, 2'b00};
  endfunction

  // address phase held until hready, then data phase until hready again
  task automatic busXfer(input logic [31:0] a, input logic wr, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    // read data taken at the edge that ends the data phase
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    busXfer(a, 1'b1, d, q);
  endtask

  task automatic expectReg(input string what, input logic [31:0] a, input logic [31:0] mask,
                           input logic [31:0] exp);
    logic [31:0] q;
    busXfer(a, 1'b0, '0, q);
    check(what, q & mask, exp);
  endtask

  task automatic bpCase(input bp_mode_type m, input bp_act_type a, input logic pre,
                        input logic [31:0] tgt, input int n, input logic post);
    wr(chAddr(0, REG_CTRL), (32'h1 << CTL_BPEN) | (32'(m) << CTL_BPMODE) | (32'(a) << CTL_BPACT));
    wr(chAddr(0, REG_CMD), (32'h1 << CMD_FORCE) | (32'(!pre) << CMD_FORCEVAL));
    repeat (2) @(posedge clk);
    check("bp set", {31'h0, bpOut[0]}, {31'h0, !pre});
    wr(chAddr(0, REG_CMD), (32'h1 << CMD_FORCE) | (32'(pre) << CMD_FORCEVAL));
    repeat (2) @(posedge clk);
    check("bp preset", {31'h0, bpOut[0]}, {31'h0, pre});
    wr(chAddr(0, REG_BPPOS), tgt);
    wr(chAddr(0, REG_CMD), 32'h1 << CMD_ARMBP);
    u_enc.move(0, n);
    check("bp hit", {31'h0, bpOut[0]}, {31'h0, post});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    expectReg("ctrl rst", chAddr(0, REG_CTRL), 32'hffff_ffff, CTRL_RST);
    expectReg("stat rst", chAddr(0, REG_STAT), 32'hffff_ffff, 32'h4);
    expectReg("unmapped", 32'h90, 32'hffff_ffff, 32'h0);
    check("okay resp", {31'h0, hresp}, 32'h0);
    // counting and direction, channels independent
    u_enc.move(0, 8);
    expectReg("pos up", chAddr(0, REG_POS), 32'hffff_ffff, 32'h8);
    u_enc.move(0, -3);
    expectReg("pos down", chAddr(0, REG_POS), 32'hffff_ffff, 32'h5);
    expectReg("pos other", chAddr(1, REG_POS), 32'hffff_ffff, 32'h0);
    wr(chAddr(2, REG_POS), 32'hffff_ffff);
    u_enc.move(2, -1);
    expectReg("pos signed", chAddr(2, REG_POS), 32'hffff_ffff, 32'hffff_fffe);
    u_enc.jump(2);
    expectReg("pos jump", chAddr(2, REG_POS), 32'hffff_ffff, 32'hffff_fffe);
    expectReg("dec err", chAddr(2, REG_STAT), 32'h20, 32'h20);
    // two jumps on channel 0 leave its phase and count where they were
    u_enc.jump(0);
    u_enc.jump(0);
    expectReg("dec err 0", chAddr(0, REG_STAT), 32'h20, 32'h20);
    wr(chAddr(2, REG_CMD), 32'h1 << CMD_CLRERR);
    expectReg("err clr", chAddr(2, REG_STAT), 32'h20, 32'h0);
    // inverting phase A alone looks like one forward step
    wr(chAddr(3, REG_CTRL), 32'h1 << CTL_POLA);
    repeat (16) @(posedge clk);
    expectReg("pol pos", chAddr(3, REG_POS), 32'hffff_ffff, 32'h1);
    expectReg("pol lvl", chAddr(3, REG_STAT), 32'hf00, 32'h100);
    wr(chAddr(1, REG_CTRL), 32'h8 << CTL_FILT);
    u_enc.glitch(1, 3);
    expectReg("glitch", chAddr(1, REG_POS), 32'hffff_ffff, 32'h0);
    u_enc.move(1, 1);
    expectReg("filt pos", chAddr(1, REG_POS), 32'hffff_ffff, 32'h1);
    // reference search: default pattern needs both phases low
    wr(chAddr(0, REG_CMD), 32'h1 << CMD_ARMIDX);
    expectReg("searching", chAddr(0, REG_STAT), 32'h3, 32'h2);
    u_enc.marker(0);
    expectReg("bad marker", chAddr(0, REG_STAT), 32'h3, 32'h2);
    u_enc.move(0, -1);
    u_enc.marker(0);
    expectReg("idx found", chAddr(0, REG_STAT), 32'h3, 32'h1);
    expectReg("idx pos", chAddr(0, REG_IDX), 32'hffff_ffff, 32'h4);
    wr(chAddr(0, REG_CTRL), 32'h1 << CTL_PATA);
    wr(chAddr(0, REG_CMD), 32'h1 << CMD_ARMIDX);
    u_enc.marker(0);
    expectReg("pat miss", chAddr(0, REG_STAT), 32'h3, 32'h2);
    u_enc.move(0, 1);
    u_enc.marker(0);
    expectReg("pat idx", chAddr(0, REG_IDX), 32'hffff_ffff, 32'h5);
    // trigger capture, hold until re-armed, then falling sense
    wr(chAddr(0, REG_CTRL), 32'h1 << CTL_TRIGEN);
    wr(chAddr(0, REG_CMD), 32'h1 << CMD_ARMCAP);
    u_enc.trig(0, 1'b1);
    expectReg("cap", chAddr(0, REG_CAP), 32'hffff_ffff, 32'h5);
    expectReg("cap flags", chAddr(0, REG_STAT), 32'h84, 32'h84);
    u_enc.move(0, 2);
    u_enc.trig(0, 1'b0);
    u_enc.trig(0, 1'b1);
    expectReg("cap held", chAddr(0, REG_CAP), 32'hffff_ffff, 32'h5);
    wr(chAddr(0, REG_CMD), 32'h1 << CMD_CLRTRIG);
    expectReg("trig clr", chAddr(0, REG_STAT), 32'h80, 32'h0);
    wr(chAddr(0, REG_CTRL), (32'h1 << CTL_TRIGEN) | (32'h1 << CTL_TRIGINV));
    wr(chAddr(0, REG_CMD), 32'h1 << CMD_ARMCAP);
    u_enc.trig(0, 1'b0);
    expectReg("cap fall", chAddr(0, REG_CAP), 32'hffff_ffff, 32'h7);
    // breakpoints: one mode and one action per case
    wr(chAddr(0, REG_BPPER), 32'h4);
    bpCase(BP_ABS, ACT_RISE, 1'b0, 32'h9, 2, 1'b1);
    expectReg("bp done", chAddr(0, REG_STAT), 32'h10, 32'h10);
    bpCase(BP_REL, ACT_FALL, 1'b1, 32'hffff_fffe, -2, 1'b0);
    bpCase(BP_MOD, ACT_TOGGLE, 1'b0, 32'h8, 1, 1'b1);
    u_enc.move(0, 4);
    check("bp modulo", {31'h0, bpOut[0]}, 32'h0);
    // halt: a level already high must not trigger
    wr(32'h80, 32'h1);
    repeat (16) @(posedge clk);
    check("halt level", {29'h0, driveInhibit, dacZero, stepStop}, 32'h0);
    haltIn <= 1'b0;
    repeat (16) @(posedge clk);
    haltIn <= 1'b1;
    repeat (16) @(posedge clk);
    check("halt edge", {29'h0, driveInhibit, dacZero, stepStop}, 32'h7);
    expectReg("halted", 32'h84, 32'h1, 32'h1);
    wr(32'h84, 32'h1);
    repeat (2) @(posedge clk);
    check("halt clr", {29'h0, driveInhibit, dacZero, stepStop}, 32'h0);
    close_out();
  end
endmodule
